// ==== cfgregs.sv ====
// read-only security and build configuration registers on apb
// Contract
// - bit N zero marks peripheral request interface N as secure
// - bit N one marks peripheral request interface N as non-secure
// - security bits are loaded as the device leaves reset
// - security bits above the last implemented interface read zero
// - build register reports buffer, width and issuing capability
// - bits 29:20 hold data buffer lines minus one
// - read queue depth-1 in 19:16, write queue depth-1 in 11:8
// - outstanding reads-1 in 14:12, outstanding writes-1 in 6:4
// - bits 2:0 encode bus width: 010, 011, 100
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "cfgregs_consts.svh"
module cfgregs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] boot_periph_ns,
  output logic [31:0] periph_nonsecure_bits
);
  cfgregs_pkg::bus_state_t state_reg;
  cfgregs_pkg::bus_state_t state_next;
  logic [31:0] build_word;
  logic sec_loaded;
  logic setup;
  sec_capture u_sec (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .boot_periph_ns(boot_periph_ns),
    .periph_nonsecure_bits(periph_nonsecure_bits),
    .loaded(sec_loaded)
  );
  always_comb begin
    build_word = 32'h0000_0000;
    build_word[`BUF_LINES_MSB:`BUF_LINES_LSB] = `BUF_LINES_M1;
    build_word[`RD_Q_MSB:`RD_Q_LSB] = `RD_Q_M1;
    build_word[`WR_Q_MSB:`WR_Q_LSB] = `WR_Q_M1;
    build_word[`RD_CAP_MSB:`RD_CAP_LSB] = `RD_CAP_M1;
    build_word[`WR_CAP_MSB:`WR_CAP_LSB] = `WR_CAP_M1;
    build_word[`WIDTH_MSB:`WIDTH_LSB] = `BUS_WIDTH_CODE;
  end
  // data are registered in the setup cycle so the access phase needs no wait
  assign setup = psel && !penable;
  always_comb begin
    state_next = state_reg;
    if (setup) begin
      state_next.rdata = 32'h0000_0000;
      state_next.pslverr = 1'b0;
      if (pwrite) begin
        state_next.pslverr = 1'b1;
      end else begin
        case (paddr)
          `SECURITY_CFG_OFFSET: state_next.rdata = periph_nonsecure_bits;
          `BUILD_CFG_OFFSET: state_next.rdata = build_word;
          default: state_next.pslverr = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= '{rdata: 32'h0000_0000, pslverr: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end
  // no wait states: every word is ready by the end of the setup cycle
  assign pready = 1'b1;
  // read data stay put until the next setup, so a slow master still sees them
  assign prdata = state_reg.rdata;
  // the error flag is only shown in the access phase, as the bus expects
  assign pslverr = psel && penable && state_reg.pslverr;
  // setup cycles of each kind and the access cycle that follows them
  sequence rd_setup_s(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence wr_setup_s;
    psel && !penable && pwrite;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  sequence stray_setup_s;
    psel && !penable && !pwrite && paddr != `SECURITY_CFG_OFFSET
      && paddr != `BUILD_CFG_OFFSET;
  endsequence
  sec_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`SECURITY_CFG_OFFSET) |=> prdata == $past(periph_nonsecure_bits))
    else $error("security read mismatch");
  build_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata == build_word && !pslverr)
    else $error("build read mismatch");
  buf_field_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata[29:20] == `BUF_LINES_M1)
    else $error("buffer field wrong");
  queue_fields_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata[19:16] == `RD_Q_M1 && prdata[11:8] == `WR_Q_M1)
    else $error("queue field wrong");
  cap_fields_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata[14:12] == `RD_CAP_M1 && prdata[6:4] == `WR_CAP_M1)
    else $error("capability field wrong");
  width_code_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    build_word[2:0] inside {`WIDTH_32, `WIDTH_64, `WIDTH_128})
    else $error("reserved width code");
  write_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_setup_s ##1 access_s |-> pslverr)
    else $error("write not refused");
  sec_nochange_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sec_loaded && psel && pwrite |=> $stable(periph_nonsecure_bits))
    else $error("write changed security bits");
  property sec_nonsec_p;
    @(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`SECURITY_CFG_OFFSET) |=> (prdata & ~$past(periph_nonsecure_bits)) == 32'h0000_0000;
  endproperty
  sec_nonsec_a: assert property (sec_nonsec_p)
    else $error("non-secure bit without strap");
  property sec_upper_p;
    @(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`SECURITY_CFG_OFFSET) |=> (prdata >> `NUM_PERIPH_REQ) == 32'h0000_0000;
  endproperty
  sec_upper_a: assert property (sec_upper_p)
    else $error("upper security bits set");
  property reserved_zero_p;
    @(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata[31:30] == 2'h0 && !prdata[15] && !prdata[7] && !prdata[3];
  endproperty
  reserved_zero_a: assert property (reserved_zero_p)
    else $error("reserved build bit set");
  property width_read_p;
    @(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`BUILD_CFG_OFFSET) |=> prdata[2:0] == `BUS_WIDTH_CODE;
  endproperty
  width_read_a: assert property (width_read_p)
    else $error("width code read wrong");
  property ready_high_p;
    @(posedge clk_sys) disable iff (!rstn)
    access_s |-> pready;
  endproperty
  ready_high_a: assert property (ready_high_p)
    else $error("access not ready");
  property err_idle_p;
    @(posedge clk_sys) disable iff (!rstn)
    !(psel && penable) |-> !pslverr;
  endproperty
  err_idle_a: assert property (err_idle_p)
    else $error("error outside access");
  property rdata_hold_p;
    @(posedge clk_sys) disable iff (!rstn)
    !(psel && !penable) |=> $stable(prdata);
  endproperty
  rdata_hold_a: assert property (rdata_hold_p)
    else $error("read data moved without setup");
  property read_ok_p;
    @(posedge clk_sys) disable iff (!rstn)
    rd_setup_s(`SECURITY_CFG_OFFSET) ##1 access_s |-> !pslverr;
  endproperty
  read_ok_a: assert property (read_ok_p)
    else $error("mapped read refused");
  property stray_err_p;
    @(posedge clk_sys) disable iff (!rstn)
    stray_setup_s ##1 access_s |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  stray_err_a: assert property (stray_err_p)
    else $error("unmapped read not refused");
  property write_data_p;
    @(posedge clk_sys) disable iff (!rstn)
    wr_setup_s |=> prdata == 32'h0000_0000;
  endproperty
  write_data_a: assert property (write_data_p)
    else $error("write returned data");
  property read_quiet_p;
    @(posedge clk_sys) disable iff (!rstn)
    sec_loaded ##0 rd_setup_s(`SECURITY_CFG_OFFSET) |=> $stable(periph_nonsecure_bits);
  endproperty
  read_quiet_a: assert property (read_quiet_p)
    else $error("read changed security bits");
  property reset_clear_p;
    @(posedge clk_sys)
    !rstn |=> prdata == 32'h0000_0000 && periph_nonsecure_bits == 32'h0000_0000;
  endproperty
  reset_clear_a: assert property (reset_clear_p)
    else $error("reset left state behind");
  property early_zero_p;
    @(posedge clk_sys) disable iff (!rstn)
    !sec_loaded |-> periph_nonsecure_bits == 32'h0000_0000;
  endproperty
  early_zero_a: assert property (early_zero_p)
    else $error("security bits before load");
  // load two edges after release; straps settle during the first
  property load_order_p;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> !sec_loaded ##1 !sec_loaded ##1 sec_loaded;
  endproperty
  load_order_a: assert property (load_order_p)
    else $error("security load out of step");
  property loaded_stays_p;
    @(posedge clk_sys) disable iff (!rstn)
    sec_loaded |=> sec_loaded;
  endproperty
  loaded_stays_a: assert property (loaded_stays_p)
    else $error("security load dropped");
endmodule : cfgregs

// ==== cfgregs_consts.svh ====
// offsets, field positions and build values of the configuration registers
`ifndef CFGREGS_CONSTS_SVH
`define CFGREGS_CONSTS_SVH
`define SECURITY_CFG_OFFSET 12'h000
`define BUILD_CFG_OFFSET 12'h004
`define NUM_PERIPH_REQ 6'h10
`define BUF_LINES_MSB 29
`define BUF_LINES_LSB 20
`define RD_Q_MSB 19
`define RD_Q_LSB 16
`define RD_CAP_MSB 14
`define RD_CAP_LSB 12
`define WR_Q_MSB 11
`define WR_Q_LSB 8
`define WR_CAP_MSB 6
`define WR_CAP_LSB 4
`define WIDTH_MSB 2
`define WIDTH_LSB 0
`define BUF_LINES_M1 10'h0ff
`define RD_Q_M1 4'h7
`define WR_Q_M1 4'h7
`define RD_CAP_M1 3'h3
`define WR_CAP_M1 3'h3
`define WIDTH_32 3'h2
`define WIDTH_64 3'h3
`define WIDTH_128 3'h4
`define BUS_WIDTH_CODE 3'h3
`endif

// ==== cfgregs_pkg.sv ====
// types shared by the configuration register bank
package cfgregs_pkg;
  typedef enum logic [1:0] {
    SEC_NONE,
    SEC_LOAD,
    SEC_HELD
  } sec_state_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic pslverr;
  } bus_state_t;
endpackage : cfgregs_pkg

// ==== sec_capture.sv ====
// captures the per-interface security straps once after reset is released
`timescale 1ns/1ps
`include "cfgregs_consts.svh"
module sec_capture (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] boot_periph_ns,
  output logic [31:0] periph_nonsecure_bits,
  output logic loaded
);
  typedef struct packed {
    cfgregs_pkg::sec_state_t st;
    logic [31:0] bits;
  } cap_t;
  cap_t state_reg;
  cap_t state_next;
  logic [31:0] impl_mask;
  // unimplemented interfaces always read zero
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      impl_mask[i] = (6'(i) < `NUM_PERIPH_REQ);
    end
  end
  always_comb begin
    state_next = state_reg;
    case (state_reg.st)
      cfgregs_pkg::SEC_NONE: state_next.st = cfgregs_pkg::SEC_LOAD;
      cfgregs_pkg::SEC_LOAD: begin
        state_next.bits = boot_periph_ns & impl_mask;
        state_next.st = cfgregs_pkg::SEC_HELD;
      end
      cfgregs_pkg::SEC_HELD: state_next = state_reg;
      default: state_next.st = cfgregs_pkg::SEC_NONE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= '{st: cfgregs_pkg::SEC_NONE, bits: 32'h0000_0000};
    end else begin
      state_reg <= state_next;
    end
  end
  assign periph_nonsecure_bits = state_reg.bits;
  assign loaded = (state_reg.st == cfgregs_pkg::SEC_HELD);
  upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (periph_nonsecure_bits & ~impl_mask) == 32'h0000_0000)
    else $error("unimplemented security bit set");
  frozen_bits_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    loaded |=> $stable(periph_nonsecure_bits))
    else $error("security bits changed after load");
endmodule : sec_capture

// ==== test_dma_security_and_build_config.sv ====
// self-checking bench for the read-only configuration register bank
`timescale 1ns/1ps
`include "cfgregs_consts.svh"
module test_dma_security_and_build_config;
  logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, boot_periph_ns = 32'h0;
  logic [31:0] prdata, periph_nonsecure_bits, rd, straps, keep;
  logic pready, pslverr, err;
  int bad_count = 0, num_checks = 0, i;
  cfgregs DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_periph_ns(boot_periph_ns),
    .periph_nonsecure_bits(periph_nonsecure_bits));
  always #25 clk_sys = ~clk_sys;
  function automatic logic [31:0] build_word();
    build_word = 32'h0;
    build_word[`BUF_LINES_MSB:`BUF_LINES_LSB] = `BUF_LINES_M1;
    build_word[`RD_Q_MSB:`RD_Q_LSB] = `RD_Q_M1;
    build_word[`RD_CAP_MSB:`RD_CAP_LSB] = `RD_CAP_M1;
    build_word[`WR_Q_MSB:`WR_Q_LSB] = `WR_Q_M1;
    build_word[`WR_CAP_MSB:`WR_CAP_LSB] = `WR_CAP_M1;
    build_word[`WIDTH_MSB:`WIDTH_LSB] = `BUS_WIDTH_CODE;
  endfunction : build_word
  // bits above the last implemented interface must read zero
  function automatic logic [31:0] mask();
    mask = (32'h1 << `NUM_PERIPH_REQ) - 32'h1;
  endfunction : mask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task chk_err(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s err got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_err
  task results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // the answer is taken at the edge that sees pready high, then released
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      $display("BAD %0t no ready", $time);
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task do_reset(input logic [31:0] s);
    @(posedge clk_sys);
    rstn <= 1'b0;
    boot_periph_ns <= s;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // later strap changes must not leak into the captured bits
    boot_periph_ns <= ~s;
    @(negedge clk_sys);
    chk(periph_nonsecure_bits, s & mask(), "captured");
  endtask : do_reset
  initial begin
    void'($urandom(32'h427bcbe9));
    for (i = 0; i < 5; i++) begin
      straps = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
      do_reset(straps);
      apb(1'b0, `SECURITY_CFG_OFFSET, 32'h0);
      chk(rd, straps & mask(), "security");
      chk_err(err, 1'b0, "sec err");
      keep = rd;
      apb(1'b1, `SECURITY_CFG_OFFSET, $urandom);
      chk_err(err, 1'b1, "wr err");
      apb(1'b0, `BUILD_CFG_OFFSET, 32'h0);
      chk(rd, build_word(), "build");
      chk({31'h0, rd[2:0] inside {3'h2, 3'h3, 3'h4}}, 32'h1, "width");
      apb(1'b1, `BUILD_CFG_OFFSET, $urandom);
      chk_err(err, 1'b1, "build wr err");
      apb(1'b0, `BUILD_CFG_OFFSET, 32'h0);
      chk(rd, build_word(), "build kept");
      apb(1'b0, `SECURITY_CFG_OFFSET, 32'h0);
      chk(rd, keep, "sec kept");
      apb(1'b0, {10'($urandom_range(1023, 2)), 2'b00}, 32'h0);
      chk_err(err, 1'b1, "unmapped err");
      chk(rd, 32'h0, "unmapped data");
      $display("test %0d done", i);
    end
    results();
  end
endmodule : test_dma_security_and_build_config
